// [hdl/tbg_gpio.sv]
// Three 8-bit GPIO ports behind an APB register slave.
// Assumes pins arrive asynchronously and alternate-function outputs
// come from logic on pclk.
//
// Operation
// - Eight pins per port; bit or byte access.
// - Direction bit 0 output, 1 input.
// - Output pins drive their latch bit.
// - Data read returns pin level for inputs.
// - Data read returns latch for outputs.
// - Writes to input bits only update latch.
// - Writes to output bits drive pins immediately.
// - Reset makes every pin an input.
// - Alternate outputs ORed with latch on port A.
// - Port A pulse, sync-in and sync-out alternates.
// - Port B pull-up per bit, resets zero.
// - Port B pins feed eight key-return inputs.
// - Port C is plain I/O only.
`timescale 1ns/100ps
`default_nettype none
module tbg_gpio #(
    parameter int unsigned W = tbg_pkg::PORT_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [W-1:0] port_a_pin_in,
    output logic [W-1:0] port_a_pin_out,
    output logic [W-1:0] port_a_pin_oe,
    input wire logic pulse_out_0,
    input wire logic pulse_out_1,
    input wire logic pulse_out_2,
    input wire logic pulse_out_3,
    input wire logic vertical_sync_output,
    input wire logic horizontal_sync_output_0,
    input wire logic horizontal_sync_output_1,
    output logic composite_sync_input,
    input wire logic [W-1:0] port_b_pin_in,
    output logic [W-1:0] port_b_pin_out,
    output logic [W-1:0] port_b_pin_oe,
    output logic [W-1:0] port_b_pullup_en,
    output logic [W-1:0] key_return_input,
    input wire logic [W-1:0] port_c_pin_in,
    output logic [W-1:0] port_c_pin_out,
    output logic [W-1:0] port_c_pin_oe
);

    localparam int unsigned N = tbg_pkg::PORT_N;

    ////////////////////////////////////////////////////////////////////
    // Declarations.
    tbg_pkg::tbg_apb_st_t st_q, st_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic [W-1:0] pullup_q, pullup_d;

    logic [tbg_pkg::IDX_W-1:0] idx;
    logic commit;
    logic hit;
    logic [31:0] rd_word;

    // Per-port views, indexed 0 for port A, 1 for B and 2 for C.
    logic [W-1:0] dmask [N];
    logic [W-1:0] rmask [N];
    logic [W-1:0] wbyte [N];
    logic [W-1:0] pu_mask;
    logic [W-1:0] pu_wdata;
    logic [W-1:0] alt [N];
    logic [W-1:0] rdata_arr [N];
    logic [W-1:0] dir_arr [N];
    logic [W-1:0] level_arr [N];
    logic [W-1:0] pin_in_arr [N];
    logic [W-1:0] pin_out_arr [N];
    logic [W-1:0] pin_oe_arr [N];

    // Bit-access fields taken from the write data.
    logic [1:0] ba_sel;
    logic [1:0] ba_port;
    logic [2:0] ba_num;
    logic ba_val;
    logic [W-1:0] ba_onehot;

    tbg_port_if #(.W(W)) port_if [N] ();

    ////////////////////////////////////////////////////////////////////
    // Address decode; the low two address bits are ignored.
    // The bus carries no byte strobe here, so an 8-bit store arrives
    // as a whole word and only its low byte is used.
    assign idx = paddr[31:2];

    // A transfer completes at the edge where pready is seen high.
    assign commit = (st_q == tbg_pkg::APB_RESP) && psel && penable;

    assign ba_sel = pwdata[tbg_pkg::BA_SEL_LSB +: 2];
    assign ba_port = pwdata[tbg_pkg::BA_PORT_LSB +: 2];
    assign ba_num = pwdata[tbg_pkg::BA_NUM_LSB +: 3];
    assign ba_val = pwdata[tbg_pkg::BA_VAL_BIT];
    assign ba_onehot = W'(1) << ba_num;

    ////////////////////////////////////////////////////////////////////
    // Pin arrays for the three slices.
    assign pin_in_arr[0] = port_a_pin_in;
    assign pin_in_arr[1] = port_b_pin_in;
    assign pin_in_arr[2] = port_c_pin_in;

    // Port A alternates; pin 4 is a sync input, so nothing is ORed
    // there. Port C has none at all. The alternate peripherals run on
    // pclk, so their outputs need no synchroniser; an asynchronous
    // source would have to be retimed before it reaches these inputs.
    always_comb begin
        alt[0] = '0;
        alt[0][0] = pulse_out_0;
        alt[0][1] = pulse_out_1;
        alt[0][2] = pulse_out_2;
        alt[0][3] = pulse_out_3;
        alt[0][5] = vertical_sync_output;
        alt[0][6] = horizontal_sync_output_0;
        alt[0][7] = horizontal_sync_output_1;
        alt[1] = '0;
        alt[2] = '0;
    end

    ////////////////////////////////////////////////////////////////////
    // One slice per port, joined through its own interface.
    for (genvar g = 0; g < N; g++) begin : g_port
        assign port_if[g].data_mask = dmask[g];
        assign port_if[g].dir_mask = rmask[g];
        assign port_if[g].wdata = wbyte[g];
        // The OR only makes sense with latch and direction cleared
        // by software first; hardware does not enforce that.
        assign port_if[g].alt_or = alt[g];
        assign rdata_arr[g] = port_if[g].rdata;
        assign dir_arr[g] = port_if[g].dir;
        assign level_arr[g] = port_if[g].pin_level;

        tbg_port #(.W(W)) u_port (
            .pclk(pclk),
            .presetn(presetn),
            .bus(port_if[g]),
            .pin_in(pin_in_arr[g]),
            .pin_out(pin_out_arr[g]),
            .pin_oe(pin_oe_arr[g])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // Write masks: a byte write sets all eight, a bit write one.
    // Bit writes let software touch a single pin without a
    // read-modify-write that could race a pin change.
    always_comb begin
        pu_mask = '0;
        pu_wdata = '0;
        for (int p = 0; p < N; p++) begin
            dmask[p] = '0;
            rmask[p] = '0;
            wbyte[p] = '0;
            if (commit && pwrite) begin
                if (idx == tbg_pkg::DATA_IDX[p]) begin
                    dmask[p] = '1;
                    wbyte[p] = pwdata[W-1:0];
                end
                if (idx == tbg_pkg::DIR_IDX[p]) begin
                    rmask[p] = '1;
                    wbyte[p] = pwdata[W-1:0];
                end
                if (idx == tbg_pkg::IDX_BIT_ACCESS
                        && ba_port == 2'(p)) begin
                    wbyte[p] = {W{ba_val}};
                    if (ba_sel == tbg_pkg::BA_SEL_LATCH) begin
                        dmask[p] = ba_onehot;
                    end
                    if (ba_sel == tbg_pkg::BA_SEL_DIR) begin
                        rmask[p] = ba_onehot;
                    end
                end
            end
        end
        if (commit && pwrite) begin
            if (idx == tbg_pkg::IDX_B_PULLUP) begin
                pu_mask = '1;
                pu_wdata = pwdata[W-1:0];
            end
            if (idx == tbg_pkg::IDX_BIT_ACCESS
                    && ba_port == tbg_pkg::PORT_B
                    && ba_sel == tbg_pkg::BA_SEL_PULLUP) begin
                pu_mask = ba_onehot;
                pu_wdata = {W{ba_val}};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux; the bit-access register reads as zero.
    // There is no single-bit read path: software reads the byte and
    // masks it, which costs nothing since pins are sampled anyway.
    always_comb begin
        hit = 1'b0;
        rd_word = '0;
        for (int p = 0; p < N; p++) begin
            if (idx == tbg_pkg::DATA_IDX[p]) begin
                hit = 1'b1;
                rd_word[W-1:0] = rdata_arr[p];
            end
            if (idx == tbg_pkg::DIR_IDX[p]) begin
                hit = 1'b1;
                rd_word[W-1:0] = dir_arr[p];
            end
        end
        if (idx == tbg_pkg::IDX_B_PULLUP) begin
            hit = 1'b1;
            rd_word[W-1:0] = pullup_q;
        end
        if (idx == tbg_pkg::IDX_BIT_ACCESS) begin
            hit = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, so read data and the error flag
    // come from flops rather than from the address decode.
    always_comb begin
        st_d = st_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        unique case (st_q)
            tbg_pkg::APB_IDLE: begin
                if (psel && penable) begin
                    st_d = tbg_pkg::APB_RESP;
                    pready_d = 1'b1;
                    pslverr_d = ~hit;
                    prdata_d = pwrite ? '0 : rd_word;
                end
            end
            tbg_pkg::APB_RESP: begin
                // Always back to idle, so a setup cycle that follows
                // the completing edge at once is taken like any other.
                st_d = tbg_pkg::APB_IDLE;
            end
        endcase
    end

    // Bus response registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= tbg_pkg::APB_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            st_q <= st_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Port B pull-up control. The resistor itself sits in the pad;
    // this block only hands out the enable, one bit per pin.
    always_comb begin
        pullup_d = (pullup_q & ~pu_mask) | (pu_wdata & pu_mask);
    end

    // Pull-ups start disconnected.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_q <= W'(tbg_pkg::PULLUP_RESET);
        end else begin
            pullup_q <= pullup_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs; all come straight from flops here or in the slices.
    // Keeping them registered means no decode glitch reaches a pin.
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign port_b_pullup_en = pullup_q;
    assign port_a_pin_out = pin_out_arr[0];
    assign port_a_pin_oe = pin_oe_arr[0];
    assign port_b_pin_out = pin_out_arr[1];
    assign port_b_pin_oe = pin_oe_arr[1];
    assign port_c_pin_out = pin_out_arr[2];
    assign port_c_pin_oe = pin_oe_arr[2];

    // Synchronised pin levels feed the alternate inputs. No noise
    // filter sits here; a glitch longer than a clock gets through.
    assign composite_sync_input = level_arr[0][tbg_pkg::A_SYNC_IN_PIN];
    assign key_return_input = level_arr[1];

endmodule : tbg_gpio
`default_nettype wire

// [hdl/tbg_pkg.sv]
// Constants and types shared by the three-port GPIO block.
// Assumes a 32-bit APB with word-aligned registers.
package tbg_pkg;

    localparam int unsigned PORT_W = 8;
    localparam int unsigned PORT_N = 3;
    localparam int unsigned IDX_W = 30;

    // Register indices; byte address is four times the index.
    localparam logic [29:0] IDX_A_DATA = 30'h0FFFF080;
    localparam logic [29:0] IDX_B_DATA = 30'h0FFFF082;
    localparam logic [29:0] IDX_C_DATA = 30'h0FFFF084;
    localparam logic [29:0] IDX_A_DIR = 30'h0FFFF0A0;
    localparam logic [29:0] IDX_B_DIR = 30'h0FFFF0A1;
    localparam logic [29:0] IDX_C_DIR = 30'h0FFFF0A2;
    localparam logic [29:0] IDX_B_PULLUP = 30'h0FFFF0AA;
    localparam logic [29:0] IDX_BIT_ACCESS = 30'h0FFFF0B0;
    localparam logic [29:0] DATA_IDX [0:2] = '{IDX_A_DATA, IDX_B_DATA,
        IDX_C_DATA};
    localparam logic [29:0] DIR_IDX [0:2] = '{IDX_A_DIR, IDX_B_DIR,
        IDX_C_DIR};

    // Reset values.
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [7:0] PULLUP_RESET = 8'h00;

    // Bit-access register fields.
    localparam int unsigned BA_SEL_LSB = 0;
    localparam int unsigned BA_PORT_LSB = 2;
    localparam int unsigned BA_NUM_LSB = 4;
    localparam int unsigned BA_VAL_BIT = 7;

    // Port numbers and port-A pin roles.
    localparam logic [1:0] PORT_A = 2'h0;
    localparam logic [1:0] PORT_B = 2'h1;
    localparam int unsigned A_SYNC_IN_PIN = 4;

    typedef enum logic [1:0] {
        BA_SEL_LATCH = 2'h0,
        BA_SEL_DIR = 2'h1,
        BA_SEL_PULLUP = 2'h2
    } tbg_bsel_t;

    typedef enum logic {
        APB_IDLE,
        APB_RESP
    } tbg_apb_st_t;

endpackage : tbg_pkg

// [hdl/tbg_port_if.sv]
// Carrier between the register logic and one port slice.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps
`default_nettype none
interface tbg_port_if #(parameter int unsigned W = 8);
    logic [W-1:0] data_mask;
    logic [W-1:0] dir_mask;
    logic [W-1:0] wdata;
    logic [W-1:0] alt_or;
    logic [W-1:0] rdata;
    logic [W-1:0] dir;
    logic [W-1:0] pin_level;

    modport ctl (output data_mask, output dir_mask, output wdata,
        output alt_or, input rdata, input dir, input pin_level);
    modport port (input data_mask, input dir_mask, input wdata,
        input alt_or, output rdata, output dir, output pin_level);
endinterface : tbg_port_if
`default_nettype wire

// [hdl/tbg_port.sv]
// One 8-bit port slice: latch, direction, pin sync and pin drive.
// Assumes write masks are pulses valid for a single clock edge.
`timescale 1ns/100ps
`default_nettype none
module tbg_port #(
    parameter int unsigned W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    tbg_port_if.port bus,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe
);

    logic [W-1:0] latch_q, latch_d;
    logic [W-1:0] dir_q, dir_d;
    logic [W-1:0] sync1_q, sync1_d;
    logic [W-1:0] sync2_q, sync2_d;
    logic [W-1:0] out_q, out_d;
    logic [W-1:0] oe_q, oe_d;

    ////////////////////////////////////////////////////////////////////
    // Next values; the latch is written whatever the direction.
    always_comb begin
        latch_d = (latch_q & ~bus.data_mask) | (bus.wdata & bus.data_mask);
        dir_d = (dir_q & ~bus.dir_mask) | (bus.wdata & bus.dir_mask);
        sync1_d = pin_in;
        sync2_d = sync1_q;
        // Drive follows the new latch at the same edge, so a write
        // to an output pin shows with no further action.
        out_d = latch_d | bus.alt_or;
        oe_d = ~dir_d;
    end

    // All registers; direction resets to input.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q <= W'(tbg_pkg::LATCH_RESET);
            dir_q <= W'(tbg_pkg::DIR_RESET);
            sync1_q <= '0;
            sync2_q <= '0;
            out_q <= '0;
            oe_q <= '0;
        end else begin
            latch_q <= latch_d;
            dir_q <= dir_d;
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read view: pin level for inputs, latch for outputs.
    assign bus.rdata = (dir_q & sync2_q) | (~dir_q & latch_q);
    assign bus.dir = dir_q;
    assign bus.pin_level = sync2_q;
    assign pin_out = out_q;
    assign pin_oe = oe_q;

endmodule : tbg_port
`default_nettype wire

// [verif/tbg_pin_model.sv]
// Board model for the pins of the three ports.
// Assumes the bench gives board levels and a float mask for port B.
`timescale 1ns/100ps
`default_nettype none
module tbg_pin_model (
    input wire logic [2:0][7:0] oe,
    input wire logic [2:0][7:0] drv,
    input wire logic [2:0][7:0] ext,
    input wire logic [7:0] flt,
    input wire logic [7:0] pull,
    output logic [2:0][7:0] lvl
);
    // Driven bits follow the device, the rest follow the board.
    // A floated port B bit without pull-up reads the inverse of the
    // board value, so a missing pull-up cannot pass by chance.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            lvl[i] = (oe[i] & drv[i]) | (~oe[i] & ext[i]);
        end
        lvl[1] = (oe[1] & drv[1]) | (~oe[1] & ~flt & ext[1])
            | (~oe[1] & flt & (pull | ~ext[1]));
    end
endmodule : tbg_pin_model
`default_nettype wire

// [verif/tbg_gpio_monitor.sv]
// Checker for the three-port GPIO block, bound to its top module.
// Assumes one clock, pclk, and the asynchronous reset presetn.
`timescale 1ns/100ps
`default_nettype none
module tbg_gpio_monitor #(
    parameter int unsigned W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [W-1:0] port_a_pin_in,
    input wire logic [W-1:0] port_a_pin_out,
    input wire logic [W-1:0] port_a_pin_oe,
    input wire logic pulse_out_0,
    input wire logic pulse_out_1,
    input wire logic pulse_out_2,
    input wire logic pulse_out_3,
    input wire logic vertical_sync_output,
    input wire logic horizontal_sync_output_0,
    input wire logic horizontal_sync_output_1,
    input wire logic composite_sync_input,
    input wire logic [W-1:0] port_b_pin_in,
    input wire logic [W-1:0] port_b_pin_oe,
    input wire logic [W-1:0] port_b_pullup_en,
    input wire logic [W-1:0] key_return_input,
    input wire logic [W-1:0] port_c_pin_oe
);
    logic [3:0] run_q;
    logic [3:0] run_d;
    logic [7:0] alt_v;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Saturating count since reset; the pin synchronisers need it.
    always_comb begin
        run_d = (run_q == 4'hF) ? run_q : run_q + 4'h1;
    end
    // The count restarts at every reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 4'h0;
        end else begin
            run_q <= run_d;
        end
    end

    // Alternate outputs in pin order; pin 4 is an input, no OR term.
    assign alt_v = {horizontal_sync_output_1, horizontal_sync_output_0,
        vertical_sync_output, 1'b0, pulse_out_3, pulse_out_2,
        pulse_out_1, pulse_out_0};

    ////////////////////////////////////////////////////////////////////
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready held longer than one cycle");
    property p_ready_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("pready late after access cycle");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("pslverr without pready");
    property p_reset_input;
        $rose(presetn) |-> (port_a_pin_oe | port_b_pin_oe
            | port_c_pin_oe) == '0;
    endproperty
    a_reset_input: assert property (p_reset_input)
        else $error("pin driven right after reset");
    property p_oe_write;
        $changed(port_c_pin_oe) |-> $past(psel && penable && pready
            && pwrite);
    endproperty
    a_oe_write: assert property (p_oe_write)
        else $error("drive enable moved without a write");
    property p_pull_write;
        $changed(port_b_pullup_en) |-> $past(psel && penable && pready
            && pwrite);
    endproperty
    a_pull_write: assert property (p_pull_write)
        else $error("pull-up moved without a write");
    property p_alt_or;
        run_q > 4'h1 |-> (alt_v & $past(alt_v) & ~port_a_pin_out) == 8'h00;
    endproperty
    a_alt_or: assert property (p_alt_or)
        else $error("alternate output missing on port A");
    property p_sync_in;
        (run_q > 4'h9 && $stable(port_a_pin_in[4]))[*5]
            |-> composite_sync_input == port_a_pin_in[4];
    endproperty
    a_sync_in: assert property (p_sync_in)
        else $error("sync input differs from pin level");
    property p_key_ret;
        (run_q > 4'h9 && $stable(port_b_pin_in))[*5]
            |-> key_return_input == port_b_pin_in;
    endproperty
    a_key_ret: assert property (p_key_ret)
        else $error("key return differs from pin level");
endmodule : tbg_gpio_monitor

bind tbg_gpio tbg_gpio_monitor #(.W(W)) u_mon (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .port_a_pin_in(port_a_pin_in),
    .port_a_pin_out(port_a_pin_out), .port_a_pin_oe(port_a_pin_oe),
    .pulse_out_0(pulse_out_0), .pulse_out_1(pulse_out_1),
    .pulse_out_2(pulse_out_2), .pulse_out_3(pulse_out_3),
    .vertical_sync_output(vertical_sync_output),
    .horizontal_sync_output_0(horizontal_sync_output_0),
    .horizontal_sync_output_1(horizontal_sync_output_1),
    .composite_sync_input(composite_sync_input),
    .port_b_pin_in(port_b_pin_in), .port_b_pin_oe(port_b_pin_oe),
    .port_b_pullup_en(port_b_pullup_en),
    .key_return_input(key_return_input), .port_c_pin_oe(port_c_pin_oe));
`default_nettype wire

// [verif/testbench.sv]
// Bench for the GPIO block: APB master, pin model, read-back queue.
// Assumes tbg_pkg, the design, its checker and the pin model compiled.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, csync;
    logic [31:0] paddr, pwdata, prdata, r;
    logic [31:0] seed = 32'h570A;
    logic [6:0] alt;
    logic [7:0] flt, pu, kr;
    logic [2:0][7:0] ext;
    wire logic [2:0][7:0] oe, drv, lvl;
    logic [32:0] expq [$];
    int num_errors, checks_done;

    tbg_gpio DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_a_pin_in(lvl[0]),
        .port_a_pin_out(drv[0]), .port_a_pin_oe(oe[0]),
        .pulse_out_0(alt[0]), .pulse_out_1(alt[1]), .pulse_out_2(alt[2]),
        .pulse_out_3(alt[3]), .vertical_sync_output(alt[4]),
        .horizontal_sync_output_0(alt[5]),
        .horizontal_sync_output_1(alt[6]), .composite_sync_input(csync),
        .port_b_pin_in(lvl[1]), .port_b_pin_out(drv[1]),
        .port_b_pin_oe(oe[1]), .port_b_pullup_en(pu),
        .key_return_input(kr), .port_c_pin_in(lvl[2]),
        .port_c_pin_out(drv[2]), .port_c_pin_oe(oe[2]));
    tbg_pin_model u_pins (.oe(oe), .drv(drv), .ext(ext), .flt(flt),
        .pull(pu), .lvl(lvl));

    // Free-running bus clock, 25 ns period.
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function logic [7:0] ba(input logic [1:0] s, input logic [1:0] p,
        input logic [2:0] n, input logic v);
        return {v, n, p, s};
    endfunction : ba
    task automatic chk_rd(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_rd
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        chk_rd({25'h0, got}, {25'h0, exp});
    endtask : chk_pin
    // Holds the request until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [29:0] idx,
        input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [29:0] idx, input logic [7:0] e,
        input logic err);
        expq.push_back({err, 24'h0, e});
        apb(1'b0, idx, 8'h00);
    endtask : rd
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // Read results are matched against the oldest noted expectation.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk_rd({pslverr, prdata}, expq.pop_front());
        end
    end

    // A hang ends the run; the tests need well under 2000 cycles.
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////
    // Test sequence: reset, ports, bit access, alternates, pull-ups.
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {alt, flt, ext} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk_pin(oe[0] | oe[1] | oe[2], 8'h00);
        for (int p = 0; p < 3; p++) begin
            rd(tbg_pkg::DIR_IDX[p], 8'hFF, 1'b0);
        end
        rd(tbg_pkg::IDX_B_PULLUP, 8'h00, 1'b0);
        rd(30'h4, 8'h00, 1'b1);
        $display("test reset done");
        // Latch, direction and read-back on every port.
        for (int p = 0; p < 3; p++) begin
            r = xs();
            @(posedge pclk);
            ext[p] <= r[7:0];
            apb(1'b1, tbg_pkg::DATA_IDX[p], r[15:8]);
            @(negedge pclk);
            chk_pin(oe[p], 8'h00);
            rd(tbg_pkg::DATA_IDX[p], r[7:0], 1'b0);
            apb(1'b1, tbg_pkg::DIR_IDX[p], r[23:16]);
            @(negedge pclk);
            chk_pin(oe[p], ~r[23:16]);
            chk_pin(drv[p] & ~r[23:16], r[15:8] & ~r[23:16]);
            rd(tbg_pkg::DIR_IDX[p], r[23:16], 1'b0);
            rd(tbg_pkg::DATA_IDX[p], (r[15:8] & ~r[23:16])
                | (r[7:0] & r[23:16]), 1'b0);
            apb(1'b1, tbg_pkg::DATA_IDX[p], r[31:24]);
            @(negedge pclk);
            chk_pin(drv[p] & ~r[23:16], r[31:24] & ~r[23:16]);
        end
        $display("test ports done");
        // Single-bit access on port C, then a pull-up select it lacks.
        apb(1'b1, tbg_pkg::IDX_BIT_ACCESS, ba(2'h0, 2'h2, 3'h5, 1'b1));
        apb(1'b1, tbg_pkg::IDX_BIT_ACCESS, ba(2'h1, 2'h2, 3'h5, 1'b0));
        apb(1'b1, tbg_pkg::IDX_BIT_ACCESS, ba(2'h2, 2'h2, 3'h0, 1'b1));
        @(negedge pclk);
        chk_pin(oe[2] & drv[2] & 8'h20, 8'h20);
        chk_pin(pu, 8'h00);
        rd(tbg_pkg::IDX_BIT_ACCESS, 8'h00, 1'b0);
        $display("test bit access done");
        // Alternate outputs on port A with latch cleared and only pin 4 set as an input.
        apb(1'b1, tbg_pkg::IDX_A_DATA, 8'h00);
        apb(1'b1, tbg_pkg::IDX_A_DIR, 8'h10);
        for (int k = 0; k < 4; k++) begin
            r = xs();
            @(posedge pclk);
            alt <= r[6:0];
            ext[0] <= {3'h0, r[7], 4'h0};
            repeat (6) @(posedge pclk);
            @(negedge pclk);
            chk_pin(drv[0], {r[6:4], 1'b0, r[3:0]});
            chk_pin({7'h0, csync}, {7'h0, r[7]});
        end
        $display("test alternates done");
        // Pull-ups on floated port B pins, then key return levels.
        apb(1'b1, tbg_pkg::IDX_B_PULLUP, 8'hA5);
        apb(1'b1, tbg_pkg::IDX_B_DIR, 8'hFF);
        apb(1'b1, tbg_pkg::IDX_BIT_ACCESS, ba(2'h2, 2'h1, 3'h1, 1'b1));
        r = xs();
        @(posedge pclk);
        ext[1] <= r[7:0];
        flt <= 8'hFF;
        repeat (3) @(posedge pclk);
        rd(tbg_pkg::IDX_B_DATA, 8'hA7 | ~r[7:0], 1'b0);
        rd(tbg_pkg::IDX_B_PULLUP, 8'hA7, 1'b0);
        flt <= 8'h00;
        repeat (6) @(posedge pclk);
        @(negedge pclk);
        chk_pin(pu, 8'hA7);
        chk_pin(kr, r[7:0]);
        $display("test pull-up done");
        repeat (2) @(posedge pclk);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
